// *** hw/dacdb_defines.svh ***
`ifndef DACDB_DEFINES_SVH
`define DACDB_DEFINES_SVH

// minimum pulse widths in ns, and the clock period in ns
`define DACDB_CLK_PERIOD_NS   8
`define DACDB_CS_LOW_NS       100
`define DACDB_BYTE_PULSE_NS   100
`define DACDB_CONV_PULSE_NS   100
`define DACDB_SETUP_NS        0
// least times round up to whole cycles, never below one
`define DACDB_CYC_UP(ns)      ((((ns) + `DACDB_CLK_PERIOD_NS - 1) / `DACDB_CLK_PERIOD_NS) < 1 ? 1 : \
                               (((ns) + `DACDB_CLK_PERIOD_NS - 1) / `DACDB_CLK_PERIOD_NS))
`define DACDB_CS_LOW_CYC      `DACDB_CYC_UP(`DACDB_CS_LOW_NS)
`define DACDB_BYTE_PULSE_CYC  `DACDB_CYC_UP(`DACDB_BYTE_PULSE_NS)
`define DACDB_CONV_PULSE_CYC  `DACDB_CYC_UP(`DACDB_CONV_PULSE_NS)
`define DACDB_SETUP_CYC       `DACDB_CYC_UP(`DACDB_SETUP_NS)
// strobe pattern positions: convert, high, low
`define DACDB_POS_CONV        2
`define DACDB_POS_HIGH        1
`define DACDB_POS_LOW         0
// pin levels after reset: select released, strobes low
`define DACDB_SEL_N_RESET     1'h1
`define DACDB_STROBE_RESET    3'h0

`endif

// *** hw/dacdb_pkg.sv ***
package dacdb_pkg;
    // sequencer states of the host
    typedef enum logic [2:0] {
        DACDB_IDLE,
        DACDB_SETUP,
        DACDB_PULSE,
        DACDB_GAP,
        DACDB_DONE
    } dacdb_state_t;

    // which access the host is making
    typedef enum logic [1:0] {
        DACDB_OP_LOW,
        DACDB_OP_HIGH,
        DACDB_OP_BOTH,
        DACDB_OP_CONV
    } dacdb_op_t;
endpackage

// *** hw/dacdb_pulse_timer.sv ***
`include "dacdb_defines.svh"

// counts down a pulse width; done is high on the last cycle of the count
module dacdb_pulse_timer #(
    parameter int WIDTH = 8
) (
    input  wire logic             sys_clk_in,
    input  wire logic             reset_in,
    input  wire logic             load_in,
    input  wire logic [WIDTH-1:0] count_in,
    output logic                  done_out
);
    logic [WIDTH-1:0] remain;

    initial begin
        if (WIDTH < 2) $error("dacdb_pulse_timer: WIDTH too small");
    end

    // loaded with the cycle count, stops at one
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            remain <= '0;
        end else if (load_in) begin
            remain <= count_in;
        end else if (remain > WIDTH'(1)) begin
            remain <= remain - WIDTH'(1);
        end
    end

    assign done_out = (remain <= WIDTH'(1)) && !load_in;
endmodule // dacdb_pulse_timer

// *** hw/dacdb_host.sv ***
`include "dacdb_defines.svh"

module dacdb_host #(
    parameter int BUS16 = 0  // 1: drive 16 data pins and load both bytes at once
) (
    // clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        reset_in,
    // user command port
    input  wire logic        write_in,
    input  wire logic [15:0] word_in,
    input  wire logic        pass_through_in,
    output logic             ready_out,
    output logic             done_out,
    // pins toward the converter
    output logic             dev_sel_n_out,
    output logic             low_byte_load_out,
    output logic             high_byte_load_out,
    output logic             convert_load_out,
    output logic [15:0]      data_out
);
    localparam int TW = 8;

    dacdb_pkg::dacdb_state_t state;
    dacdb_pkg::dacdb_op_t    op;
    logic [15:0]             word;
    logic                    through;
    logic                    low_done;
    logic                    high_done;
    logic                    tmr_load;
    logic [TW-1:0]           tmr_count;
    logic                    tmr_done;
    logic [2:0]              strobes;

    initial begin
        if (BUS16 != 0 && BUS16 != 1) $error("dacdb_host: BUS16 must be 0 or 1");
        if (`DACDB_CS_LOW_CYC >= (1 << TW)) $error("dacdb_host: pulse count too wide");
    end

    dacdb_pulse_timer #(
        .WIDTH(TW)
    ) u_timer (
        .sys_clk_in(sys_clk_in),
        .reset_in  (reset_in),
        .load_in   (tmr_load),
        .count_in  (tmr_count),
        .done_out  (tmr_done)
    );

    // minimum width count
    // pulse width: the longer of the strobe time and the select time
    assign tmr_count = TW'(`DACDB_BYTE_PULSE_CYC > `DACDB_CS_LOW_CYC ?
                           `DACDB_BYTE_PULSE_CYC : `DACDB_CS_LOW_CYC);
    assign tmr_load  = (state == dacdb_pkg::DACDB_SETUP);

    // only legal patterns
    // strobe pattern for the current access, convert/high/low
    always_comb begin
        strobes = `DACDB_STROBE_RESET;
        unique case (op)
            dacdb_pkg::DACDB_OP_LOW:  strobes = 3'h1;
            dacdb_pkg::DACDB_OP_HIGH: strobes = 3'h2;
            dacdb_pkg::DACDB_OP_BOTH: strobes = through ? 3'h7 : 3'h3;
            dacdb_pkg::DACDB_OP_CONV: strobes = 3'h4;
        endcase
    end

    // sequencer: on 8-bit bus low, high, convert; on 16-bit bus both, convert; pass-through one access of all three
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state     <= dacdb_pkg::DACDB_IDLE;
            op        <= dacdb_pkg::DACDB_OP_LOW;
            word      <= 16'h0000;
            through   <= 1'h0;
            low_done  <= 1'h0;
            high_done <= 1'h0;
        end else begin
            unique case (state)
                dacdb_pkg::DACDB_IDLE: begin
                    if (write_in) begin
                        word      <= word_in;
                        through   <= pass_through_in;
                        low_done  <= 1'h0;
                        high_done <= 1'h0;
                        // pass-through uses 111 with select low
                        op        <= (BUS16 == 1 || pass_through_in) ? dacdb_pkg::DACDB_OP_BOTH
                                                                     : dacdb_pkg::DACDB_OP_LOW;
                        state     <= dacdb_pkg::DACDB_SETUP;
                    end
                end
                dacdb_pkg::DACDB_SETUP: state <= dacdb_pkg::DACDB_PULSE;
                dacdb_pkg::DACDB_PULSE: begin
                    if (tmr_done) begin
                        state <= dacdb_pkg::DACDB_GAP;
                        if (op == dacdb_pkg::DACDB_OP_LOW)  low_done  <= 1'h1;
                        if (op == dacdb_pkg::DACDB_OP_HIGH) high_done <= 1'h1;
                        if (op == dacdb_pkg::DACDB_OP_BOTH) begin
                            low_done  <= 1'h1;
                            high_done <= 1'h1;
                        end
                    end
                end
                dacdb_pkg::DACDB_GAP: begin
                    // convert only after both bytes loaded; pass-through strobes all three at once and goes straight to DONE
                    if (op == dacdb_pkg::DACDB_OP_CONV || through) begin
                        state <= dacdb_pkg::DACDB_DONE;
                    end else if (!high_done) begin
                        op    <= dacdb_pkg::DACDB_OP_HIGH;
                        state <= dacdb_pkg::DACDB_SETUP;
                    end else begin
                        op    <= dacdb_pkg::DACDB_OP_CONV;
                        state <= dacdb_pkg::DACDB_SETUP;
                    end
                end
                dacdb_pkg::DACDB_DONE: state <= dacdb_pkg::DACDB_IDLE;
            endcase
        end
    end

    // pins: select and data set up in SETUP, strobes only in PULSE
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            dev_sel_n_out      <= `DACDB_SEL_N_RESET;
            low_byte_load_out  <= 1'h0;
            high_byte_load_out <= 1'h0;
            convert_load_out   <= 1'h0;
            data_out           <= 16'h0000;
        end else begin
            // select low only around our access
            dev_sel_n_out <= !(state == dacdb_pkg::DACDB_SETUP || state == dacdb_pkg::DACDB_PULSE);
            // high byte on both halves of the data lines for the high access on 8-bit bus
            if (BUS16 == 0 && op == dacdb_pkg::DACDB_OP_HIGH) begin
                data_out <= {word[15:8], word[15:8]};
            end else begin
                data_out <= word;
            end
            // strobe held full width then dropped
            // stays up through the timer's last cycle, else the pulse is one cycle short of the count
            if (state == dacdb_pkg::DACDB_PULSE) begin
                low_byte_load_out  <= strobes[`DACDB_POS_LOW];
                high_byte_load_out <= strobes[`DACDB_POS_HIGH];
                convert_load_out   <= strobes[`DACDB_POS_CONV];
            end else begin
                low_byte_load_out  <= 1'h0;
                high_byte_load_out <= 1'h0;
                convert_load_out   <= 1'h0;
            end
        end
    end

    // user handshake
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            ready_out <= 1'h0;
            done_out  <= 1'h0;
        end else begin
            ready_out <= (state == dacdb_pkg::DACDB_IDLE) && !write_in;
            done_out  <= (state == dacdb_pkg::DACDB_DONE);
        end
    end

    // assertions
    // no invalid patterns
    property p_no_invalid;
        @(posedge sys_clk_in) disable iff (reset_in)
        !({convert_load_out, high_byte_load_out, low_byte_load_out} inside {3'h5, 3'h6}) &&
        ({convert_load_out, high_byte_load_out, low_byte_load_out} != 3'h3 || BUS16 == 1);
    endproperty
    a_no_invalid: assert property (p_no_invalid) else $error("invalid strobe pattern");

    property p_low_width;
        @(posedge sys_clk_in) disable iff (reset_in)
        $rose(low_byte_load_out) |-> low_byte_load_out [*8] ##1 low_byte_load_out [*5];
    endproperty
    a_low_width: assert property (p_low_width) else $error("low strobe too short");

    property p_high_width;
        @(posedge sys_clk_in) disable iff (reset_in)
        $rose(high_byte_load_out) |-> high_byte_load_out [*8] ##1 high_byte_load_out [*5];
    endproperty
    a_high_width: assert property (p_high_width) else $error("high strobe too short");

    property p_conv_width;
        @(posedge sys_clk_in) disable iff (reset_in)
        $rose(convert_load_out) |-> convert_load_out [*8] ##1 convert_load_out [*5];
    endproperty
    a_conv_width: assert property (p_conv_width) else $error("convert strobe too short");

    property p_sel_low;
        @(posedge sys_clk_in) disable iff (reset_in)
        $fell(dev_sel_n_out) |-> !dev_sel_n_out [*8] ##1 !dev_sel_n_out [*6];
    endproperty
    a_sel_low: assert property (p_sel_low) else $error("select low too short");

    property p_strobe_sel;
        @(posedge sys_clk_in) disable iff (reset_in)
        (low_byte_load_out || high_byte_load_out) |-> !dev_sel_n_out;
    endproperty
    a_strobe_sel: assert property (p_strobe_sel) else $error("byte strobe without select");

    property p_conv_after_bytes;
        @(posedge sys_clk_in) disable iff (reset_in)
        $rose(convert_load_out) |-> (low_done && high_done) || (low_byte_load_out && high_byte_load_out);
    endproperty
    a_conv_after_bytes: assert property (p_conv_after_bytes) else $error("convert before word assembled");

    property p_sel_setup;
        @(posedge sys_clk_in) disable iff (reset_in)
        $rose(low_byte_load_out || high_byte_load_out) |-> $past(!dev_sel_n_out);
    endproperty
    a_sel_setup: assert property (p_sel_setup) else $error("select not set up before strobe");

    property p_done_bound;
        @(posedge sys_clk_in) disable iff (reset_in)
        (state == dacdb_pkg::DACDB_IDLE && write_in && !pass_through_in) |-> ##[20:60] done_out;
    endproperty
    a_done_bound: assert property (p_done_bound) else $error("write not finished in time");

    // one access of 15 cycles, then done and its register
    property p_done_through;
        @(posedge sys_clk_in) disable iff (reset_in)
        (state == dacdb_pkg::DACDB_IDLE && write_in && pass_through_in) |-> ##[16:18] done_out;
    endproperty
    a_done_through: assert property (p_done_through) else $error("pass-through not finished in time");

    c_low: cover property (@(posedge sys_clk_in) disable iff (reset_in) $rose(low_byte_load_out));
    c_conv: cover property (@(posedge sys_clk_in) disable iff (reset_in) $rose(convert_load_out));
    c_through: cover property (@(posedge sys_clk_in) disable iff (reset_in)
        low_byte_load_out && high_byte_load_out && convert_load_out);
    c_done: cover property (@(posedge sys_clk_in) disable iff (reset_in) done_out);
endmodule // dacdb_host

// *** tb/dacdb_dev_model.sv ***
// behavioural converter input latches: two byte latches, then the converter latch
module dacdb_dev_model (
    // pins from the host
    input  wire logic        sel_n_in,
    input  wire logic        low_in,
    input  wire logic        high_in,
    input  wire logic        conv_in,
    input  wire logic [15:0] data_in,
    // word held by the converter latch
    output logic [15:0]      dac_word_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] low_reg;
    logic [7:0] high_reg;

    always_latch begin
        if (!sel_n_in && low_in) begin
            low_reg <= data_in[7:0];
        end
    end

    always_latch begin
        if (!sel_n_in && high_in) begin
            high_reg <= data_in[15:8];
        end
    end

    always_latch begin
        if (conv_in) begin
            dac_word_out <= {high_reg, low_reg};
        end
    end
endmodule // dacdb_dev_model

// *** tb/tb_top.sv ***
`include "dacdb_defines.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk_in = 1'b0;
    logic        reset_in, write_in, pass_through_in, ready_out, done_out;
    logic        dev_sel_n_out, low_byte_load_out, high_byte_load_out, convert_load_out;
    logic [15:0] word_in, data_out, dac_word, prev_word;
    int          n_fail = 0;
    int          n_tests = 0;
    int          seed = 19;
    int          cnt_lo = 0, cnt_hi = 0, cnt_cv = 0, cnt_sel = 0;

    dacdb_host #(.BUS16(0)) dut (
        .sys_clk_in(sys_clk_in), .reset_in(reset_in), .write_in(write_in), .word_in(word_in),
        .pass_through_in(pass_through_in), .ready_out(ready_out), .done_out(done_out),
        .dev_sel_n_out(dev_sel_n_out), .low_byte_load_out(low_byte_load_out),
        .high_byte_load_out(high_byte_load_out), .convert_load_out(convert_load_out), .data_out(data_out));
    dacdb_dev_model dev (
        .sel_n_in(dev_sel_n_out), .low_in(low_byte_load_out), .high_in(high_byte_load_out),
        .conv_in(convert_load_out), .data_in(data_out), .dac_word_out(dac_word));

    // 125 MHz clock
    always #4 sys_clk_in = ~sys_clk_in;

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // the converter must end up holding exactly the written word
    function automatic logic [15:0] exp_dac(input logic [15:0] w);
        return w;
    endfunction

    task automatic test_done();
        $display("Counts: %0d compares, %0d mismatches", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // checks a pulse width when it ends, then advances the count
    task automatic pulse_width(input logic act, input int min, inout int cnt);
        if (!act && cnt > 0) chk1(cnt >= min, 1'h1);
        cnt = act ? cnt + 1 : 0;
    endtask

    // pin monitor, sampled on the falling edge where registered pins have settled
    always @(negedge sys_clk_in) begin
        if (reset_in) begin
            cnt_lo = 0; cnt_hi = 0; cnt_cv = 0; cnt_sel = 0;
        end else begin
            if ({convert_load_out, high_byte_load_out, low_byte_load_out} inside {3'h3, 3'h5, 3'h6})
                chk1(1'h0, 1'h1);
            if (low_byte_load_out || high_byte_load_out) chk1(dev_sel_n_out, 1'h0);
            pulse_width(low_byte_load_out, `DACDB_BYTE_PULSE_CYC, cnt_lo);
            pulse_width(high_byte_load_out, `DACDB_BYTE_PULSE_CYC, cnt_hi);
            pulse_width(convert_load_out, `DACDB_CONV_PULSE_CYC, cnt_cv);
            pulse_width(!dev_sel_n_out, `DACDB_CS_LOW_CYC, cnt_sel);
            if (!convert_load_out) chk16(dac_word, prev_word);
        end
        prev_word = dac_word;
    end

    // one write; poke raises write_in mid-transfer with another word, which must be ignored
    task automatic do_write(input logic [15:0] w, input logic pt, input logic poke);
        int i;
        i = 0;
        while (ready_out !== 1'b1 && i < 100) begin
            @(negedge sys_clk_in);
            i++;
        end
        chk1(ready_out, 1'h1);
        write_in = 1'b1;
        word_in = w;
        pass_through_in = pt;
        @(negedge sys_clk_in);
        write_in = 1'b0;
        if (poke) begin
            repeat (20) @(negedge sys_clk_in);
            chk1(ready_out, 1'h0);
            write_in = 1'b1;
            word_in = ~w;
            @(negedge sys_clk_in);
            write_in = 1'b0;
        end
        i = 0;
        while (done_out !== 1'b1 && i < 200) begin
            @(negedge sys_clk_in);
            i++;
        end
        chk1(done_out, 1'h1);
        chk16(dac_word, exp_dac(w));
        $display("test done: word %h pass %0d", w, pt);
    endtask

    initial begin
        logic [15:0] w;
        reset_in = 1'b1;
        write_in = 1'b0;
        word_in = 16'h0000;
        pass_through_in = 1'b0;
        repeat (4) @(negedge sys_clk_in);
        chk1(dev_sel_n_out, `DACDB_SEL_N_RESET);
        chk1(convert_load_out, 1'h0);
        reset_in = 1'b0;
        do_write(16'h0000, 1'b0, 1'b0);
        do_write(16'hFFFF, 1'b0, 1'b0);
        do_write(16'hA55A, 1'b0, 1'b1);
        do_write(16'h3CC3, 1'b1, 1'b0);
        // random words, some through the transparent path
        for (int k = 0; k < 8; k++) begin
            w = 16'($random(seed));
            do_write(w, 1'($random(seed) % 4 == 0), 1'b0);
        end
        // reset in mid-transfer drops the pins, then the next write must still land whole
        write_in = 1'b1;
        word_in = 16'h1234;
        @(negedge sys_clk_in);
        write_in = 1'b0;
        repeat (10) @(negedge sys_clk_in);
        reset_in = 1'b1;
        @(negedge sys_clk_in);
        chk1(dev_sel_n_out, `DACDB_SEL_N_RESET);
        chk1(low_byte_load_out, 1'h0);
        reset_in = 1'b0;
        do_write(16'h5AA5, 1'b0, 1'b0);
        test_done();
    end

    // watchdog: about 15 writes of at most 60 cycles, with a wide margin
    initial begin
        #100000;
        n_fail++;
        test_done();
    end
endmodule // tb_top
